// ==== include/tap_recon_pkg.sv ====
// Constants, types and the layout record for multi-tap image reconstruction
package tap_recon_pkg;

    localparam int COORD_W   = 16;
    localparam int STEP_W    = 8;
    localparam int PIX_W     = 16;
    localparam int MAX_TAPS  = 8;
    localparam int TAP_IDX_W = 3;

    localparam logic [COORD_W-1:0] COORD_ONE = 16'h0001;
    localparam logic [COORD_W-1:0] ROW_OPEN  = 16'hffff;   // Line-scan rows never close
    localparam logic [3:0]         FIELD_ABSENT = 4'h0;
    localparam logic [3:0]         FIELD_TWO    = 4'h2;

    typedef enum logic [1:0] {
        VP_TOP_LEFT     = 2'b00,
        VP_TOP_RIGHT    = 2'b01,
        VP_BOTTOM_LEFT  = 2'b10,
        VP_BOTTOM_RIGHT = 2'b11
    } vantage_e;

    typedef enum logic [1:0] {
        HEXT_ZONE_LEFT = 2'b00,
        HEXT_ENDS      = 2'b01,
        HEXT_MIDDLE    = 2'b10,
        HEXT_RSVD      = 2'b11
    } hext_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b10
    } state_e;

    typedef struct packed {
        vantage_e           vantage;
        logic               area_scan;
        logic [COORD_W-1:0] image_width_px;
        logic [COORD_W-1:0] image_height_px;
        logic [3:0]         horiz_zone_count;
        logic [3:0]         horiz_parallel_pixels;
        hext_e              horiz_extractor_place;
        logic [3:0]         vert_zone_count;
        logic [3:0]         vert_parallel_pixels;
        logic               vert_extractor_place;   // 1: top and bottom
    } cfg_s;

    localparam cfg_s CFG_RST = '{
        vantage: VP_TOP_LEFT, area_scan: 1'b1,
        image_width_px: 16'h0001, image_height_px: 16'h0001,
        horiz_zone_count: 4'h1, horiz_parallel_pixels: 4'h0,
        horiz_extractor_place: HEXT_ZONE_LEFT,
        vert_zone_count: 4'h1, vert_parallel_pixels: 4'h0,
        vert_extractor_place: 1'b0
    };

endpackage

// ==== include/tap_geom_if.sv ====
// Per-tap geometry record passed from the layout calculator to the rebuilder
`timescale 1ns/1ps
`default_nettype none
interface tap_geom_if;
    logic        [tap_recon_pkg::COORD_W-1:0] col_first;
    logic        [tap_recon_pkg::COORD_W-1:0] col_last;
    logic signed [tap_recon_pkg::STEP_W-1:0]  col_increment;
    logic        [tap_recon_pkg::COORD_W-1:0] row_first;
    logic        [tap_recon_pkg::COORD_W-1:0] row_last;
    logic signed [tap_recon_pkg::STEP_W-1:0]  row_increment;
    logic                                     used;

    modport calc (output col_first, col_last, col_increment, row_first, row_last,
                  output row_increment, used);
    modport user (input col_first, col_last, col_increment, row_first, row_last,
                  input row_increment, used);
endinterface
`default_nettype wire

// ==== logic/tap_layout_calc.sv ====
// Geometry of one tap derived from the layout code fields
`timescale 1ns/1ps
`default_nettype none
module tap_layout_calc #(
    parameter int TAP_INDEX = 0
) (
    input  wire tap_recon_pkg::cfg_s cfg,
    tap_geom_if.calc                 g
);
    int w, h, wz, hz, zx, zy, tx, ty, ntx, nty, hi, vi, z, k, zv, kv;

    // Zones are equal and disjoint, so one division fixes every zone edge
    always_comb begin
        w   = int'(cfg.image_width_px);
        h   = int'(cfg.image_height_px);
        zx  = (cfg.horiz_zone_count == 4'h0) ? 1 : int'(cfg.horiz_zone_count);
        tx  = (cfg.horiz_parallel_pixels == tap_recon_pkg::FIELD_ABSENT) ? 1
              : int'(cfg.horiz_parallel_pixels);
        // Line-scan has no vertical part: one zone, one line per output
        zy  = (cfg.area_scan && cfg.vert_zone_count == 4'h2) ? 2 : 1;
        ty  = (cfg.area_scan && cfg.vert_parallel_pixels == tap_recon_pkg::FIELD_TWO)
              ? 2 : 1;
        ntx = zx * tx;
        nty = zy * ty;
        hi  = TAP_INDEX % ntx;   // Row-major index, the tap numbering order
        vi  = TAP_INDEX / ntx;
        z   = hi / tx;
        k   = hi % tx;
        zv  = vi / ty;
        kv  = vi % ty;
        wz  = w / zx;
        hz  = h / zy;
        g.used = (TAP_INDEX < ntx * nty);
        // Horizontal placement per extractor location
        if (cfg.horiz_extractor_place == tap_recon_pkg::HEXT_MIDDLE && z == 0) begin
            g.col_first     = 16'(wz - tx + 1 + k);
            g.col_last      = 16'(1 + k);
            g.col_increment = 8'(-tx);
        end else if (cfg.horiz_extractor_place == tap_recon_pkg::HEXT_ENDS && z == 1) begin
            g.col_first     = 16'(w - tx + 1 + k);
            g.col_last      = 16'(wz + 1 + k);
            g.col_increment = 8'(-tx);
        end else begin
            g.col_first     = 16'(z * wz + 1 + k);
            g.col_last      = 16'((z + 1) * wz - tx + 1 + k);
            g.col_increment = 8'(tx);
        end
        // Vertical placement; height has no meaning on a line-scan sensor
        if (!cfg.area_scan) begin
            g.row_first     = tap_recon_pkg::COORD_ONE;
            g.row_last      = tap_recon_pkg::ROW_OPEN;
            g.row_increment = 8'sd1;
        end else if (cfg.vert_extractor_place && zv == 1) begin
            g.row_first     = 16'(h - ty + 1 + kv);
            g.row_last      = 16'(hz + 1 + kv);
            g.row_increment = 8'(-ty);
        end else begin
            g.row_first     = 16'(zv * hz + 1 + kv);
            g.row_last      = 16'((zv + 1) * hz - ty + 1 + kv);
            g.row_increment = 8'(ty);
        end
    end
endmodule
`default_nettype wire

// ==== logic/coord_mirror.sv ====
// Maps sensor coordinates to scene coordinates by the vantage point
`timescale 1ns/1ps
`default_nettype none
module coord_mirror (
    input  wire tap_recon_pkg::vantage_e           vantage,
    input  wire logic                              area_scan,
    input  wire logic [tap_recon_pkg::COORD_W-1:0] width,
    input  wire logic [tap_recon_pkg::COORD_W-1:0] height,
    input  wire logic [tap_recon_pkg::COORD_W-1:0] col_in,
    input  wire logic [tap_recon_pkg::COORD_W-1:0] row_in,
    output logic      [tap_recon_pkg::COORD_W-1:0] col_out,
    output logic      [tap_recon_pkg::COORD_W-1:0] row_out
);
    logic flip_x;
    logic flip_y;

    // Right vantages flip columns; bottom vantages flip rows (not on line-scan)
    always_comb begin
        flip_x  = (vantage == tap_recon_pkg::VP_TOP_RIGHT) ||
                  (vantage == tap_recon_pkg::VP_BOTTOM_RIGHT);
        flip_y  = area_scan && ((vantage == tap_recon_pkg::VP_BOTTOM_LEFT) ||
                  (vantage == tap_recon_pkg::VP_BOTTOM_RIGHT));
        col_out = flip_x ? 16'(width + tap_recon_pkg::COORD_ONE - col_in) : col_in;
        row_out = flip_y ? 16'(height + tap_recon_pkg::COORD_ONE - row_in) : row_in;
    end
endmodule
`default_nettype wire

// ==== logic/tap_image_rebuild.sv ====
// Places tap pixels of a multi-tap sensor at their image coordinates
`timescale 1ns/1ps
`default_nettype none
module tap_image_rebuild (
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    input  wire logic                                  frame_start,
    input  wire tap_recon_pkg::vantage_e               vantage,
    input  wire logic                                  area_scan,
    input  wire logic [tap_recon_pkg::COORD_W-1:0]     image_width_px,
    input  wire logic [tap_recon_pkg::COORD_W-1:0]     image_height_px,
    input  wire logic [3:0]                            horiz_zone_count,
    input  wire logic [3:0]                            horiz_parallel_pixels,
    input  wire tap_recon_pkg::hext_e                  horiz_extractor_place,
    input  wire logic [3:0]                            vert_zone_count,
    input  wire logic [3:0]                            vert_parallel_pixels,
    input  wire logic                                  vert_extractor_place,
    input  wire logic                                  pix_valid,
    input  wire logic [tap_recon_pkg::TAP_IDX_W-1:0]   pix_tap,
    input  wire logic [tap_recon_pkg::PIX_W-1:0]       pix_data,
    output logic                                       out_valid,
    output logic      [tap_recon_pkg::COORD_W-1:0]     out_col,
    output logic      [tap_recon_pkg::COORD_W-1:0]     out_row,
    output logic      [tap_recon_pkg::PIX_W-1:0]       out_data,
    output logic                                       busy,
    output logic                                       frame_done,
    output logic                                       layout_error
);
    localparam int NT = tap_recon_pkg::MAX_TAPS;

    tap_recon_pkg::cfg_s   cfg_r, cfg_nxt;
    tap_recon_pkg::state_e st_r, st_nxt;
    logic [tap_recon_pkg::COORD_W-1:0] col_r [NT];
    logic [tap_recon_pkg::COORD_W-1:0] col_nxt [NT];
    logic [tap_recon_pkg::COORD_W-1:0] row_r [NT];
    logic [tap_recon_pkg::COORD_W-1:0] row_nxt [NT];
    logic [NT-1:0]                     done_r, done_nxt;
    logic                              out_valid_r, out_valid_nxt;
    logic [tap_recon_pkg::COORD_W-1:0] out_col_r, out_col_nxt;
    logic [tap_recon_pkg::COORD_W-1:0] out_row_r, out_row_nxt;
    logic [tap_recon_pkg::PIX_W-1:0]   out_data_r, out_data_nxt;
    logic                              frame_done_r, frame_done_nxt;
    logic                              err_r, err_nxt;
    logic                              busy_r, busy_nxt;

    logic [tap_recon_pkg::COORD_W-1:0] xs_w [NT];
    logic [tap_recon_pkg::COORD_W-1:0] xe_w [NT];
    logic [tap_recon_pkg::COORD_W-1:0] ys_w [NT];
    logic [tap_recon_pkg::COORD_W-1:0] ye_w [NT];
    logic signed [tap_recon_pkg::STEP_W-1:0] xi_w [NT];
    logic signed [tap_recon_pkg::STEP_W-1:0] yi_w [NT];
    logic [NT-1:0]                     used_w;
    logic [tap_recon_pkg::COORD_W-1:0] sel_col, sel_row, mir_col, mir_row;
    logic                              accept;
    logic                              layout_bad;
    int                                tap_total;

    tap_geom_if geom [NT] ();

    // One calculator per tap slot holds that tap's six geometric values
    for (genvar i = 0; i < NT; i++) begin : g_tap
        tap_layout_calc #(
            .TAP_INDEX (i)
        ) u_calc (
            .cfg (cfg_r),
            .g   (geom[i].calc)
        );
        assign xs_w[i]   = geom[i].col_first;
        assign xe_w[i]   = geom[i].col_last;
        assign xi_w[i]   = geom[i].col_increment;
        assign ys_w[i]   = geom[i].row_first;
        assign ye_w[i]   = geom[i].row_last;
        assign yi_w[i]   = geom[i].row_increment;
        assign used_w[i] = geom[i].used;
    end

    coord_mirror u_mirror (
        .vantage   (cfg_r.vantage),
        .area_scan (cfg_r.area_scan),
        .width     (cfg_r.image_width_px),
        .height    (cfg_r.image_height_px),
        .col_in    (sel_col),
        .row_in    (sel_row),
        .col_out   (mir_col),
        .row_out   (mir_row)
    );

    // Membership test shared by the horizontal zone-count and parallel-pixel fields
    function automatic logic count_ok(input logic [3:0] v, input logic absent_ok);
        case (v)
            4'h0:                    count_ok = absent_ok;
            4'h1:                    count_ok = !absent_ok;
            4'h2, 4'h3, 4'h4, 4'h8,
            4'ha:                    count_ok = 1'b1;
            default:                 count_ok = 1'b0;
        endcase
    endfunction

    // Field legality; extractor letters only make sense with two zones
    always_comb begin
        tap_total  = int'(cfg_r.horiz_zone_count) *
                     ((cfg_r.horiz_parallel_pixels == 4'h0) ? 1
                      : int'(cfg_r.horiz_parallel_pixels));
        if (cfg_r.area_scan) begin
            tap_total = tap_total * ((cfg_r.vert_zone_count == 4'h2) ? 2 : 1) *
                        ((cfg_r.vert_parallel_pixels == 4'h2) ? 2 : 1);
        end
        layout_bad = !count_ok(cfg_r.horiz_zone_count, 1'b0)
                  || !count_ok(cfg_r.horiz_parallel_pixels, 1'b1)
                  || (cfg_r.horiz_extractor_place == tap_recon_pkg::HEXT_RSVD)
                  || (cfg_r.horiz_extractor_place != tap_recon_pkg::HEXT_ZONE_LEFT &&
                      cfg_r.horiz_zone_count != 4'h2)
                  || (tap_total > NT);
        if (cfg_r.area_scan) begin
            layout_bad = layout_bad
                  || !(cfg_r.vert_zone_count == 4'h1 || cfg_r.vert_zone_count == 4'h2)
                  || !(cfg_r.vert_parallel_pixels == tap_recon_pkg::FIELD_ABSENT ||
                       cfg_r.vert_parallel_pixels == tap_recon_pkg::FIELD_TWO)
                  || (cfg_r.vert_extractor_place && cfg_r.vert_zone_count != 4'h2);
        end
    end

    assign sel_col = col_r[pix_tap];
    assign sel_row = row_r[pix_tap];
    // Pixels of unused or finished taps are dropped rather than misplaced
    assign accept  = (st_r == tap_recon_pkg::ST_RUN) && pix_valid && used_w[pix_tap] &&
                     !done_r[pix_tap];

    // Frame sequencing and per-tap cursors
    always_comb begin
        st_nxt         = st_r;
        cfg_nxt        = cfg_r;
        col_nxt        = col_r;
        row_nxt        = row_r;
        done_nxt       = done_r;
        out_valid_nxt  = 1'b0;
        out_col_nxt    = out_col_r;
        out_row_nxt    = out_row_r;
        out_data_nxt   = out_data_r;
        frame_done_nxt = 1'b0;
        err_nxt        = err_r;
        case (st_r)
            tap_recon_pkg::ST_IDLE: begin
            end
            tap_recon_pkg::ST_LOAD: begin
                // Settings are latched a cycle earlier, so geometry is now stable
                err_nxt = layout_bad;
                for (int t = 0; t < NT; t++) begin
                    col_nxt[t]  = xs_w[t];
                    row_nxt[t]  = ys_w[t];
                    done_nxt[t] = !used_w[t];
                end
                st_nxt = layout_bad ? tap_recon_pkg::ST_IDLE : tap_recon_pkg::ST_RUN;
            end
            tap_recon_pkg::ST_RUN: begin
                if (accept) begin
                    out_valid_nxt = 1'b1;
                    out_col_nxt   = mir_col;
                    out_row_nxt   = mir_row;
                    out_data_nxt  = pix_data;
                    if (sel_col == xe_w[pix_tap]) begin
                        col_nxt[pix_tap] = xs_w[pix_tap];
                        row_nxt[pix_tap] = 16'(int'(sel_row) + int'(yi_w[pix_tap]));
                        // Height only closes a tap on area-scan; line-scan runs on
                        if (cfg_r.area_scan && sel_row == ye_w[pix_tap]) begin
                            done_nxt[pix_tap] = 1'b1;
                        end
                    end else begin
                        col_nxt[pix_tap] = 16'(int'(sel_col) + int'(xi_w[pix_tap]));
                    end
                end
                if (&done_nxt) begin
                    frame_done_nxt = 1'b1;
                    st_nxt         = tap_recon_pkg::ST_IDLE;
                end
            end
            default: st_nxt = tap_recon_pkg::ST_IDLE;
        endcase
        // A new frame always wins and restarts with fresh settings
        if (frame_start) begin
            cfg_nxt = '{
                vantage: vantage, area_scan: area_scan,
                image_width_px: image_width_px, image_height_px: image_height_px,
                horiz_zone_count: horiz_zone_count,
                horiz_parallel_pixels: horiz_parallel_pixels,
                horiz_extractor_place: horiz_extractor_place,
                vert_zone_count: vert_zone_count, vert_parallel_pixels: vert_parallel_pixels,
                vert_extractor_place: vert_extractor_place
            };
            st_nxt = tap_recon_pkg::ST_LOAD;
        end
        // Registered so the status pin carries no decode glitches
        busy_nxt = (st_nxt != tap_recon_pkg::ST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r         <= tap_recon_pkg::ST_IDLE;
            cfg_r        <= tap_recon_pkg::CFG_RST;
            col_r        <= '{default: '0};
            row_r        <= '{default: '0};
            done_r       <= '1;
            out_valid_r  <= 1'b0;
            out_col_r    <= '0;
            out_row_r    <= '0;
            out_data_r   <= '0;
            frame_done_r <= 1'b0;
            err_r        <= 1'b0;
            busy_r       <= 1'b0;
        end else begin
            st_r         <= st_nxt;
            cfg_r        <= cfg_nxt;
            col_r        <= col_nxt;
            row_r        <= row_nxt;
            done_r       <= done_nxt;
            out_valid_r  <= out_valid_nxt;
            out_col_r    <= out_col_nxt;
            out_row_r    <= out_row_nxt;
            out_data_r   <= out_data_nxt;
            frame_done_r <= frame_done_nxt;
            err_r        <= err_nxt;
            busy_r       <= busy_nxt;
        end
    end

    assign out_valid    = out_valid_r;
    assign out_col      = out_col_r;
    assign out_row      = out_row_r;
    assign out_data     = out_data_r;
    assign busy         = busy_r;
    assign frame_done   = frame_done_r;
    assign layout_error = err_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_vantage_default;
        $fell(rst) |-> cfg_r.vantage == tap_recon_pkg::VP_TOP_LEFT;
    endproperty
    a_vantage_default: assert property (p_vantage_default)
        else $error("vantage not top-left after reset");

    property p_line_never_done;
        !cfg_r.area_scan && st_r == tap_recon_pkg::ST_RUN && !frame_start
            |=> !frame_done_r;
    endproperty
    a_line_never_done: assert property (p_line_never_done)
        else $error("line-scan frame closed by height");

    property p_load_start;
        st_r == tap_recon_pkg::ST_LOAD && !frame_start
            |=> col_r[0] == $past(xs_w[0]) && row_r[0] == $past(ys_w[0]);
    endproperty
    a_load_start: assert property (p_load_start)
        else $error("first tap cursor not loaded from start");

    property p_col_step;
        accept && pix_tap == 3'h0 && sel_col != xe_w[0] && !frame_start
            |=> col_r[0] == 16'(int'($past(sel_col)) + int'($past(xi_w[0])));
    endproperty
    a_col_step: assert property (p_col_step)
        else $error("column did not advance by increment");

    property p_row_wrap;
        accept && pix_tap == 3'h0 && sel_col == xe_w[0] && !frame_start
            |=> col_r[0] == $past(xs_w[0]) &&
                row_r[0] == 16'(int'($past(sel_row)) + int'($past(yi_w[0])));
    endproperty
    a_row_wrap: assert property (p_row_wrap)
        else $error("row did not advance at end of line");

    property p_tap_order;
        st_r == tap_recon_pkg::ST_RUN && used_w[1] && cfg_r.area_scan &&
            !err_r && cfg_r.image_width_px >= 16'(tap_total) &&
            cfg_r.image_height_px >= 16'(tap_total)
            |-> (ys_w[0] < ys_w[1]) || (ys_w[0] == ys_w[1] && xs_w[0] < xs_w[1]);
    endproperty
    a_tap_order: assert property (p_tap_order)
        else $error("first two taps out of order");

    property p_bad_zone;
        st_r == tap_recon_pkg::ST_LOAD && !frame_start &&
            !count_ok(cfg_r.horiz_zone_count, 1'b0) |=> err_r && !busy;
    endproperty
    a_bad_zone: assert property (p_bad_zone)
        else $error("illegal zone count not flagged");

    property p_out_follows;
        accept |=> out_valid_r ##1 (out_valid_r == $past(accept));
    endproperty
    a_out_follows: assert property (p_out_follows)
        else $error("output strobe not tied to accepted pixel");

    property p_top_left_place;
        accept && cfg_r.vantage == tap_recon_pkg::VP_TOP_LEFT
            |=> out_col_r == $past(sel_col) && out_row_r == $past(sel_row);
    endproperty
    a_top_left_place: assert property (p_top_left_place)
        else $error("top-left placement altered coordinates");

    c_frame_done: cover property (cfg_r.area_scan ##0 frame_done_r);
    c_mirror:     cover property (out_valid_r && cfg_r.vantage == tap_recon_pkg::VP_BOTTOM_RIGHT);
    c_ends:       cover property (accept && cfg_r.horiz_extractor_place ==
                                  tap_recon_pkg::HEXT_ENDS);
endmodule
`default_nettype wire

// ==== verif/cam_taps.sv ====
// Camera tap model: sends tap pixels and notes where each must land
`timescale 1ns/1ps
`default_nettype none
module cam_taps (
    input  wire logic   clk,
    output logic        pix_valid,
    output logic [2:0]  pix_tap,
    output logic [15:0] pix_data
);
    logic [48:0] exp_q[$];   // Column, row, data, last of frame
    initial {pix_valid, pix_tap, pix_data} = '0;
    // Two taps in turn, one pixel a cycle, no gaps, like a real sensor
    task automatic send(input int w, h, v, a, input int g[12]);
        int nc, nr, c, r;
        nc = (g[1] - g[0]) / g[2] + 1;
        nr = (g[4] - g[3]) / g[5] + 1;
        @(negedge clk);
        {pix_valid, pix_tap} = 4'hf;     // Unused tap index, dropped
        for (int p = 0; p < nc * nr; p++)
            for (int t = 0; t < 2; t++) begin
                c = g[6*t] + (p % nc) * g[6*t+2];
                r = g[6*t+3] + (p / nc) * g[6*t+5];
                if (v[0]) c = w + 1 - c;
                if (v[1] && a) r = h + 1 - r;
                @(negedge clk);
                pix_tap  = 3'(t);
                pix_data = 16'($urandom);
                exp_q.push_back({16'(c), 16'(r), pix_data, 1'(a && t && p == nc*nr-1)});
            end
        @(negedge clk);
        pix_valid = 0;
        pix_data  = ~pix_data;   // A released line must not hold its value
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Testbench: layouts and vantages against a camera tap model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst, frame_start, area_scan, vert_extractor_place, pix_valid;
    logic out_valid, busy, frame_done, layout_error;
    logic [15:0] image_width_px, image_height_px, out_col, out_row, out_data, pix_data;
    logic [3:0] horiz_zone_count, horiz_parallel_pixels, vert_zone_count, vert_parallel_pixels;
    logic [2:0] pix_tap;
    tap_recon_pkg::vantage_e vantage;
    tap_recon_pkg::hext_e    horiz_extractor_place;
    int fail_count = 0;
    int samples_checked = 0;

    tap_image_rebuild i_tap_image_rebuild (.clk, .rst, .frame_start, .vantage, .area_scan,
        .image_width_px, .image_height_px, .horiz_zone_count, .horiz_parallel_pixels,
        .horiz_extractor_place, .vert_zone_count, .vert_parallel_pixels,
        .vert_extractor_place, .pix_valid, .pix_tap, .pix_data, .out_valid, .out_col,
        .out_row, .out_data, .busy, .frame_done, .layout_error);
    cam_taps i_cam_taps (.clk, .pix_valid, .pix_tap, .pix_data);

    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [48:0] got, input logic [48:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Settings are latched at the start pulse, then the vantage is scrambled to prove it
    task automatic frame(input int v, a, hz, hp, hx, vz, vp, vx, err, input int g[12]);
        @(negedge clk);
        vantage               = tap_recon_pkg::vantage_e'(2'(v));
        horiz_extractor_place = tap_recon_pkg::hext_e'(2'(hx));
        {area_scan, horiz_zone_count, horiz_parallel_pixels} = {1'(a), 4'(hz), 4'(hp)};
        {vert_zone_count, vert_parallel_pixels} = {4'(vz), 4'(vp)};
        {vert_extractor_place, image_height_px, frame_start} = {1'(vx), a ? 16'h2 : 16'h9, 1'b1};
        @(negedge clk);
        frame_start = 0;
        vantage = tap_recon_pkg::vantage_e'(2'(~v));
        @(negedge clk);
        chk(49'(layout_error), 49'(err));
        if (err == 0) i_cam_taps.send(4, 2, v, a, g);
        repeat (3) @(negedge clk);
        chk(49'(i_cam_taps.exp_q.size()), 49'h0);
        chk(49'(busy), 49'(a == 0));
    endtask

    // Scoreboard: each placed pixel meets the oldest note of the model
    always @(posedge clk) begin
        #1;
        if (out_valid === 1'b1)
            chk({out_col, out_row, out_data, frame_done},
                i_cam_taps.exp_q.size() ? i_cam_taps.exp_q.pop_front() : '1);
        else if ({out_valid, frame_done} !== 2'b00)
            chk(49'({out_valid, frame_done}), 49'h0);
    end

    // Watchdog far beyond the roughly 135 cycles the frames need
    initial begin
        #200000;
        fail_count++;
        conclude();
    end

    initial begin
        {rst, frame_start, area_scan, vert_extractor_place} = 4'h8;
        {image_width_px, image_height_px} = {16'h4, 16'h2};
        {horiz_zone_count, horiz_parallel_pixels, vert_zone_count, vert_parallel_pixels} = '0;
        vantage = tap_recon_pkg::VP_TOP_LEFT;
        horiz_extractor_place = tap_recon_pkg::HEXT_ZONE_LEFT;
        void'($urandom(6112));
        repeat (20) @(negedge clk);
        rst = 0;
        chk(49'({out_valid, busy, frame_done, layout_error}), 49'h0);
        frame(0, 1, 1, 2, 0, 1, 0, 0, 0, '{1, 3, 2, 1, 2, 1, 2, 4, 2, 1, 2, 1});
        frame(1, 1, 2, 0, 1, 1, 0, 0, 0, '{1, 2, 1, 1, 2, 1, 4, 3, -1, 1, 2, 1});
        frame(2, 1, 1, 0, 0, 2, 0, 1, 0, '{1, 4, 1, 1, 1, 1, 1, 4, 1, 2, 2, -1});
        frame(3, 1, 2, 0, 2, 1, 0, 0, 0, '{2, 1, -1, 1, 2, 1, 3, 4, 1, 1, 2, 1});
        frame(0, 1, 1, 0, 0, 1, 2, 0, 0, '{1, 4, 1, 1, 1, 2, 1, 4, 1, 2, 2, 2});
        frame(0, 1, 1, 0, 3, 1, 0, 0, 1, '{default: 1});
        frame(0, 1, 5, 0, 0, 1, 0, 0, 1, '{default: 1});
        frame(0, 1, 10, 0, 0, 1, 0, 0, 1, '{default: 1});
        frame(3, 0, 2, 0, 0, 2, 2, 1, 0, '{1, 2, 1, 1, 2, 1, 3, 4, 1, 1, 2, 1});
        conclude();
    end
endmodule
`default_nettype wire
